// ---- design/core_exec_consts.svh ----
`ifndef CORE_EXEC_CONSTS_SVH
`define CORE_EXEC_CONSTS_SVH
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAGS_RESET 8'h00
`define GPR_RESET 8'h00
`define PC_RESET 16'h0000
`define OFS_GPR_LAST 12'h07C
`define OFS_PC 12'h080
`define OFS_FLAGS 12'h084
`define OFS_STATE 12'h088
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
`define PC_STEP 16'h0001
`define SKIP_SHORT 16'h0002
`define SKIP_LONG 16'h0003
`define Z_LO 5'h1E
`define Z_HI 5'h1F
`define PAIR_STEP 5'h01
`endif

// ---- design/core_exec_pkg.sv ----
`default_nettype none
package core_exec_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_WORD_IMMEDIATE_ADDITION, OP_SUB,
    OP_IMMEDIATE_DIFFERENCE, OP_BORROW_DIFFERENCE, OP_BORROW_IMMEDIATE_DIFFERENCE,
    OP_WORD_IMMEDIATE_DECREASE, OP_AND, OP_CONJUNCTION_IMMEDIATE, OP_OR,
    OP_DISJUNCTION_IMMEDIATE, OP_EXCLUSIVE_DISJUNCTION, OP_BIT_SET_MASK,
    OP_BIT_CLEAR_MASK, OP_ZERO_MINUS_PROBE, OP_POINTER_JUMP, OP_RELATIVE_CALL,
    OP_POINTER_CALL, OP_EQUAL_COMPARE_SKIP, OP_IMMEDIATE_COMPARE,
    OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP,
    OP_IO_BIT_SET_SKIP, OP_FLAG_SET_BRANCH
  } op_t;
  typedef struct packed {
    op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] k;
    logic [2:0] bsel;
    logic [11:0] off;
    logic next_long;
    logic [7:0] io_val;
  } exec_req_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } exec_state_t;
endpackage : core_exec_pkg
`default_nettype wire

// ---- design/core_alu_branch_exec.sv ----
// Summary of operation
// RULE_01: add and add-carry update Z C N V H
// RULE_02: word add immediate on pair, two cycles
// RULE_03: word subtract immediate on pair, two cycles
// RULE_04: register subtract, flags Z C N V H
// RULE_05: immediate subtract into destination, one cycle
// RULE_06: subtract with borrow, registers, one cycle
// RULE_07: subtract with borrow, immediate, one cycle
// RULE_08: logic ops update only Z N V
// RULE_09: set-bits ORs mask, Z N V
// RULE_10: clear-bits ANDs inverted mask, Z N V
// RULE_11: test ANDs register with itself, flags only
// RULE_12: pointer jump loads pc from Z, two cycles
// RULE_13: relative call pushes return, three cycles
// RULE_14: pointer call pushes return, loads Z
// RULE_15: compare-skip if equal, 1/2/3 cycles
// RULE_16: compare immediate sets flags, keeps register
// RULE_17: register bit skips, clear or set
// RULE_18: io bit skips, clear or set
// RULE_19: branch on set flag, 1 or 2 cycles
// RULE_20: skip passes one whole instruction, 2 or 3
// RULE_21: signed offsets, pc wraps at its width
`include "core_exec_consts.svh"
`default_nettype none
module core_alu_branch_exec
  import core_exec_pkg::*;
#(
  parameter int PC_W = 10
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire exec_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [PC_W-1:0] pc,
  output logic [7:0] status_flags_reg,
  output logic call_push,
  output logic [PC_W-1:0] call_ret_addr,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp
);

  logic [7:0] gpr [32];
  exec_state_t state;
  logic [1:0] wait_cnt, last_cyc, cyc;
  logic accept, apb_setup, apb_wr, apb_we, gpr_hit, addr_ok, err_q;
  logic [31:0] rd_val, rd_q;
  logic [7:0] opa, opb, res8, next_flags;
  logic [8:0] sum9;
  logic [15:0] word_in, word_res, pc16, rel_target, z_ptr, next_pc16;
  logic [4:0] hi_idx;
  logic wr8, wr16, flag_we, cond, borrow, carry_in, is_call;

  assign accept = req_valid & req_ready;
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_wr = apb_req.psel & apb_req.pwrite;
  // a pending register write holds the core off so the two never collide
  assign req_ready = (state == ST_IDLE) & ~apb_wr;
  assign apb_we = apb_req.psel & apb_req.penable & apb_req.pwrite & ~err_q;
  assign apb_rsp = '{pready: 1'b1, prdata: rd_q, pslverr: err_q};

  assign hi_idx = req.rd + `PAIR_STEP;
  assign opa = gpr[req.rd];
  assign word_in = {gpr[hi_idx], opa};
  assign z_ptr = {gpr[`Z_HI], gpr[`Z_LO]};
  assign pc16 = 16'(pc);
  assign rel_target = pc16 + 16'($signed(req.off)) + `PC_STEP; // RULE_21
  assign carry_in = status_flags_reg[`FLAG_C];
  assign is_call = (req.op == OP_RELATIVE_CALL) | (req.op == OP_POINTER_CALL);

  always_comb
  begin
    case (req.op)
      OP_IMMEDIATE_DIFFERENCE, OP_BORROW_IMMEDIATE_DIFFERENCE,
      OP_CONJUNCTION_IMMEDIATE, OP_DISJUNCTION_IMMEDIATE,
      OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK, OP_IMMEDIATE_COMPARE:
        opb = req.k;
      OP_ZERO_MINUS_PROBE:
        opb = opa; // RULE_11
      default:
        opb = gpr[req.rr];
    endcase
  end

  always_comb
  begin
    sum9 = 9'h000;
    res8 = opa;
    word_res = word_in;
    next_flags = status_flags_reg;
    wr8 = 1'b0;
    wr16 = 1'b0;
    flag_we = 1'b0;
    cond = 1'b0;
    borrow = 1'b0;
    next_pc16 = pc16 + `PC_STEP;
    cyc = `CYC_ONE;
    case (req.op)
      OP_ADD, OP_ADD_CARRY:
      begin
        sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, (req.op == OP_ADD_CARRY) & carry_in}; // RULE_01
        res8 = sum9[7:0];
        wr8 = 1'b1;
        flag_we = 1'b1;
        next_flags[`FLAG_C] = sum9[8];
        next_flags[`FLAG_H] = opa[3] & opb[3] | opb[3] & ~res8[3] | ~res8[3] & opa[3];
        next_flags[`FLAG_V] = opa[7] & opb[7] & ~res8[7] | ~opa[7] & ~opb[7] & res8[7];
      end
      OP_SUB, OP_IMMEDIATE_DIFFERENCE, OP_BORROW_DIFFERENCE,
      OP_BORROW_IMMEDIATE_DIFFERENCE, OP_IMMEDIATE_COMPARE:
      begin
        borrow = carry_in & ((req.op == OP_BORROW_DIFFERENCE) |
                             (req.op == OP_BORROW_IMMEDIATE_DIFFERENCE)); // RULE_06 RULE_07
        sum9 = {1'b0, opa} - {1'b0, opb} - {8'h00, borrow}; // RULE_04 RULE_05
        res8 = sum9[7:0];
        wr8 = (req.op != OP_IMMEDIATE_COMPARE); // RULE_16
        flag_we = 1'b1;
        next_flags[`FLAG_C] = sum9[8];
        next_flags[`FLAG_H] = ~opa[3] & opb[3] | opb[3] & res8[3] | res8[3] & ~opa[3];
        next_flags[`FLAG_V] = opa[7] & ~opb[7] & ~res8[7] | ~opa[7] & opb[7] & res8[7];
      end
      OP_AND, OP_CONJUNCTION_IMMEDIATE, OP_ZERO_MINUS_PROBE, OP_OR,
      OP_DISJUNCTION_IMMEDIATE, OP_BIT_SET_MASK, OP_EXCLUSIVE_DISJUNCTION,
      OP_BIT_CLEAR_MASK:
      begin
        if (req.op == OP_OR || req.op == OP_DISJUNCTION_IMMEDIATE ||
            req.op == OP_BIT_SET_MASK)
          res8 = opa | opb; // RULE_09
        else if (req.op == OP_EXCLUSIVE_DISJUNCTION)
          res8 = opa ^ opb;
        else if (req.op == OP_BIT_CLEAR_MASK)
          res8 = opa & ~opb; // RULE_10
        else
          res8 = opa & opb;
        wr8 = 1'b1;
        flag_we = 1'b1;
        next_flags[`FLAG_V] = 1'b0; // RULE_08
      end
      OP_WORD_IMMEDIATE_ADDITION:
      begin
        word_res = word_in + {8'h00, req.k}; // RULE_02
        wr16 = 1'b1;
        flag_we = 1'b1;
        cyc = `CYC_TWO;
        next_flags[`FLAG_V] = ~word_in[15] & word_res[15];
        next_flags[`FLAG_C] = ~word_res[15] & word_in[15];
      end
      OP_WORD_IMMEDIATE_DECREASE:
      begin
        word_res = word_in - {8'h00, req.k}; // RULE_03
        wr16 = 1'b1;
        flag_we = 1'b1;
        cyc = `CYC_TWO;
        next_flags[`FLAG_V] = word_in[15] & ~word_res[15];
        next_flags[`FLAG_C] = word_res[15] & ~word_in[15];
      end
      OP_POINTER_JUMP:
      begin
        next_pc16 = z_ptr; // RULE_12
        cyc = `CYC_TWO;
      end
      OP_RELATIVE_CALL:
      begin
        next_pc16 = rel_target; // RULE_13
        cyc = `CYC_THREE;
      end
      OP_POINTER_CALL:
      begin
        next_pc16 = z_ptr; // RULE_14
        cyc = `CYC_THREE;
      end
      OP_EQUAL_COMPARE_SKIP, OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP,
      OP_IO_BIT_CLEAR_SKIP, OP_IO_BIT_SET_SKIP:
      begin
        if (req.op == OP_EQUAL_COMPARE_SKIP)
          cond = (opa == opb); // RULE_15
        else if (req.op == OP_REG_BIT_CLEAR_SKIP)
          cond = ~opb[req.bsel]; // RULE_17
        else if (req.op == OP_REG_BIT_SET_SKIP)
          cond = opb[req.bsel]; // RULE_17
        else if (req.op == OP_IO_BIT_CLEAR_SKIP)
          cond = ~req.io_val[req.bsel]; // RULE_18
        else
          cond = req.io_val[req.bsel]; // RULE_18
        // the fetch stage tells us how long the skipped instruction is
        if (cond)
        begin
          next_pc16 = pc16 + (req.next_long ? `SKIP_LONG : `SKIP_SHORT); // RULE_20
          cyc = req.next_long ? `CYC_THREE : `CYC_TWO; // RULE_20
        end
      end
      OP_FLAG_SET_BRANCH:
      begin
        cond = status_flags_reg[req.bsel]; // RULE_19
        if (cond)
        begin
          next_pc16 = rel_target; // RULE_19
          cyc = `CYC_TWO;
        end
      end
      default:
      begin
      end
    endcase
    if (wr16)
    begin
      next_flags[`FLAG_Z] = (word_res == 16'h0000);
      next_flags[`FLAG_N] = word_res[15];
      next_flags[`FLAG_S] = word_res[15] ^ next_flags[`FLAG_V];
    end
    else if (flag_we)
    begin
      next_flags[`FLAG_Z] = (res8 == 8'h00);
      next_flags[`FLAG_N] = res8[7];
    end
  end

  // working registers: bus writes only happen while the core is held idle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 32; i++)
        gpr[i] <= `GPR_RESET;
    end
    else if (apb_we && gpr_hit)
      gpr[apb_req.paddr[6:2]] <= apb_req.pwdata[7:0];
    else if (accept && wr8)
      gpr[req.rd] <= res8;
    else if (accept && wr16)
    begin
      gpr[req.rd] <= word_res[7:0]; // RULE_02 RULE_03
      gpr[hi_idx] <= word_res[15:8];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pc <= PC_W'(`PC_RESET);
    else if (apb_we && apb_req.paddr == `OFS_PC)
      pc <= apb_req.pwdata[PC_W-1:0];
    else if (accept)
      pc <= next_pc16[PC_W-1:0]; // RULE_21
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_flags_reg <= `FLAGS_RESET;
    else if (apb_we && apb_req.paddr == `OFS_FLAGS)
      status_flags_reg <= apb_req.pwdata[7:0];
    else if (accept && flag_we)
      status_flags_reg <= next_flags;
  end

  // the stack lives outside; it is handed the return address here
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      call_push <= 1'b0;
      call_ret_addr <= PC_W'(`PC_RESET);
    end
    else
    begin
      call_push <= accept & is_call; // RULE_13 RULE_14
      if (accept && is_call)
        call_ret_addr <= PC_W'(pc16 + `PC_STEP);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      wait_cnt <= 2'h0;
      last_cyc <= 2'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (accept)
          begin
            last_cyc <= cyc;
            wait_cnt <= cyc - `CYC_ONE;
            if (cyc != `CYC_ONE)
              state <= ST_BUSY;
          end
        ST_BUSY:
        begin
          wait_cnt <= wait_cnt - `CYC_ONE;
          if (wait_cnt == `CYC_ONE)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  assign gpr_hit = (apb_req.paddr <= `OFS_GPR_LAST) && (apb_req.paddr[1:0] == 2'b00);
  assign addr_ok = gpr_hit || apb_req.paddr == `OFS_PC ||
                   apb_req.paddr == `OFS_FLAGS || apb_req.paddr == `OFS_STATE;

  always_comb
  begin
    if (gpr_hit)
      rd_val = {24'h000000, gpr[apb_req.paddr[6:2]]};
    else if (apb_req.paddr == `OFS_PC)
      rd_val = 32'(pc);
    else if (apb_req.paddr == `OFS_FLAGS)
      rd_val = {24'h000000, status_flags_reg};
    else if (apb_req.paddr == `OFS_STATE)
      rd_val = {29'h00000000, last_cyc, state == ST_BUSY};
    else
      rd_val = 32'h00000000;
  end

  // answer is captured in setup so the access phase finishes in one cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_q <= 32'h00000000;
      err_q <= 1'b0;
    end
    else if (apb_setup)
    begin
      rd_q <= apb_req.pwrite ? 32'h00000000 : rd_val;
      err_q <= ~addr_ok | (apb_req.pwrite & ((apb_req.paddr == `OFS_STATE) |
                                             (state != ST_IDLE)));
    end
  end

  property p_add_sum;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_ADD |=> gpr[$past(req.rd)] == $past(8'(opa + opb));
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("add result wrong"); // RULE_01

  property p_word_time;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_WORD_IMMEDIATE_ADDITION |=> state == ST_BUSY ##1 state == ST_IDLE;
  endproperty
  a_word_time: assert property (p_word_time) else $error("word add not two cycles"); // RULE_02

  property p_word_dec;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_WORD_IMMEDIATE_DECREASE |=>
      {gpr[$past(hi_idx)], gpr[$past(req.rd)]} == $past(word_in - {8'h00, req.k});
  endproperty
  a_word_dec: assert property (p_word_dec) else $error("word decrease wrong"); // RULE_03

  property p_borrow_carry;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_BORROW_DIFFERENCE |=>
      status_flags_reg[`FLAG_C] == $past({1'b0, opa} < {1'b0, opb} + {8'h00, carry_in});
  endproperty
  a_borrow_carry: assert property (p_borrow_carry) else $error("borrow carry wrong"); // RULE_06

  property p_logic_v;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_BIT_CLEAR_MASK |=> !status_flags_reg[`FLAG_V] &&
      status_flags_reg[`FLAG_C] == $past(carry_in) &&
      gpr[$past(req.rd)] == $past(opa & ~req.k);
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("clear mask wrong"); // RULE_10

  property p_cmp_keep;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_IMMEDIATE_COMPARE |=> gpr[$past(req.rd)] == $past(opa) &&
      status_flags_reg[`FLAG_Z] == $past(opa == req.k);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep) else $error("compare changed register"); // RULE_16

  property p_ptr_jump;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_POINTER_JUMP |=>
      pc == $past(z_ptr[PC_W-1:0]) && state == ST_BUSY ##1 state == ST_IDLE;
  endproperty
  a_ptr_jump: assert property (p_ptr_jump) else $error("pointer jump wrong"); // RULE_12

  property p_call_time;
    @(posedge clk) disable iff (!rstn)
    accept && is_call |=> call_push && state == ST_BUSY ##1 state == ST_BUSY ##1
      state == ST_IDLE;
  endproperty
  a_call_time: assert property (p_call_time) else $error("call not three cycles"); // RULE_13

  property p_skip_len;
    @(posedge clk) disable iff (!rstn)
    accept && cond && req.op != OP_FLAG_SET_BRANCH |=>
      pc == PC_W'($past(pc16) + ($past(req.next_long) ? `SKIP_LONG : `SKIP_SHORT));
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip length wrong"); // RULE_20

  property p_branch;
    @(posedge clk) disable iff (!rstn)
    accept && req.op == OP_FLAG_SET_BRANCH && cond |=>
      pc == PC_W'($past(pc16) + $past(16'($signed(req.off))) + `PC_STEP);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong"); // RULE_19

  property p_flags_keep;
    @(posedge clk) disable iff (!rstn)
    accept && (req.op >= OP_POINTER_JUMP) && req.op != OP_IMMEDIATE_COMPARE |=>
      $stable(status_flags_reg);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("control op changed flags"); // RULE_15

endmodule : core_alu_branch_exec
`default_nettype wire

// ---- verif/core_fetch_model.sv ----
`default_nettype none
module core_fetch_model
  import core_exec_pkg::*;
(
  input wire logic clk,
  input wire logic req_ready,
  output exec_req_t req,
  output logic req_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req = '0;
    req_valid = 1'b0;
  end
  // offer one word, hold it until taken, then count the busy cycles
  task automatic issue(input exec_req_t r, input int gap, output int n);
    repeat (gap) @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // released bus carries garbage so a stale word cannot pass for a live one
    req <= ~r;
    n = 1;
    @(posedge clk);
    while (req_ready !== 1'b1)
    begin
      n++;
      @(posedge clk);
    end
  endtask : issue
endmodule : core_fetch_model
`default_nettype wire

// ---- verif/core_alu_branch_exec_tb.sv ----
`default_nettype none
module core_alu_branch_exec_tb import core_exec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 10;
  localparam int M = (1 << PW) - 1;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  exec_req_t req;
  logic req_valid, req_ready, call_push;
  logic [PW-1:0] pc, call_ret_addr;
  logic [7:0] status_flags_reg;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  int gpr[32];
  int flg, epc, en, epush, eret, pushes, fails, checks_done, cyc;

  always #10 clk = ~clk;

  core_alu_branch_exec #(.PC_W(PW)) core_alu_branch_exec_inst (
    .clk(clk), .rstn(rstn), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .pc(pc), .status_flags_reg(status_flags_reg), .call_push(call_push),
    .call_ret_addr(call_ret_addr), .apb_req(apb_req), .apb_rsp(apb_rsp)
  );

  core_fetch_model core_fetch_model_inst (
    .clk(clk), .req_ready(req_ready), .req(req), .req_valid(req_valid)
  );

  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cyc++;
    if (call_push === 1'b1)
      pushes++;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb_rw(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb_rw

  task automatic rd_chk(input logic [11:0] a, input int exp);
    logic [31:0] d;
    logic e;
    apb_rw(1'b0, a, 32'h0, d, e);
    check(d, exp);
    check(e, 0);
  endtask : rd_chk

  function automatic int fl(int keep, int c, int z, int n, int v, int s, int h);
    return (flg & keep) | c | (z << 1) | (n << 2) | (v << 3) | (s << 4) | (h << 5);
  endfunction : fl

  task automatic model(input exec_req_t r);
    int a, b, c, s, hi, w, z, so, old, n, v;
    a = gpr[r.rd];
    b = (r.op inside {OP_ADD, OP_ADD_CARRY, OP_SUB, OP_BORROW_DIFFERENCE, OP_AND, OP_OR,
        OP_EXCLUSIVE_DISJUNCTION, OP_EQUAL_COMPARE_SKIP}) ? gpr[r.rr] : r.k;
    c = (r.op inside {OP_ADD_CARRY, OP_BORROW_DIFFERENCE, OP_BORROW_IMMEDIATE_DIFFERENCE}) ?
        (flg & 1) : 0;
    hi = (r.rd + 1) % 32;
    w = gpr[hi] * 256 + a;
    z = gpr[31] * 256 + gpr[30];
    so = $signed(r.off);
    old = epc;
    epc = (old + 1) & M;
    en = 1;
    case (r.op)
      OP_ADD, OP_ADD_CARRY:
      begin
        s = a + b + c;
        flg = fl(8'hD0, s > 255, (s & 255) == 0, (s >> 7) & 1,
            ((a ^ s) & (b ^ s) & 128) != 0, 0, (a & 15) + (b & 15) + c > 15);
        gpr[r.rd] = s & 255;
      end
      OP_SUB, OP_IMMEDIATE_DIFFERENCE, OP_BORROW_DIFFERENCE, OP_BORROW_IMMEDIATE_DIFFERENCE,
      OP_IMMEDIATE_COMPARE:
      begin
        s = a - b - c;
        flg = fl(8'hD0, s < 0, (s & 255) == 0, (s >> 7) & 1,
            ((a ^ b) & (a ^ s) & 128) != 0, 0, (a & 15) < (b & 15) + c);
        if (r.op != OP_IMMEDIATE_COMPARE)
          gpr[r.rd] = s & 255;
      end
      OP_AND, OP_CONJUNCTION_IMMEDIATE, OP_OR, OP_DISJUNCTION_IMMEDIATE,
      OP_EXCLUSIVE_DISJUNCTION, OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK, OP_ZERO_MINUS_PROBE:
      begin
        case (r.op)
          OP_AND, OP_CONJUNCTION_IMMEDIATE: s = a & b;
          OP_EXCLUSIVE_DISJUNCTION: s = a ^ b;
          OP_BIT_CLEAR_MASK: s = a & ~b & 255;
          OP_ZERO_MINUS_PROBE: s = a;
          default: s = a | b;
        endcase
        flg = fl(8'hF1, 0, s == 0, s >> 7, 0, 0, 0);
        gpr[r.rd] = s;
      end
      OP_WORD_IMMEDIATE_ADDITION, OP_WORD_IMMEDIATE_DECREASE:
      begin
        s = (r.op == OP_WORD_IMMEDIATE_ADDITION) ? w + b : w - b;
        n = (s >> 15) & 1;
        v = (r.op == OP_WORD_IMMEDIATE_ADDITION) ? (w < 32768 && n) : (w >= 32768 && !n);
        flg = fl(8'hE0, s > 65535 || s < 0, (s & 65535) == 0, n, v, n ^ v, 0);
        gpr[r.rd] = s & 255;
        gpr[hi] = (s >> 8) & 255;
        en = 2;
      end
      OP_POINTER_JUMP:
      begin
        epc = z & M;
        en = 2;
      end
      OP_RELATIVE_CALL, OP_POINTER_CALL:
      begin
        eret = (old + 1) & M;
        epc = (r.op == OP_POINTER_CALL) ? z & M : (old + so + 1) & M;
        epush++;
        en = 3;
      end
      OP_FLAG_SET_BRANCH:
        if ((flg >> r.bsel) & 1)
        begin
          epc = (old + so + 1) & M;
          en = 2;
        end
      OP_NOP: en = 1;
      default:
      begin
        case (r.op)
          OP_EQUAL_COMPARE_SKIP: s = (a == b);
          OP_REG_BIT_CLEAR_SKIP: s = !gpr[r.rr][r.bsel];
          OP_REG_BIT_SET_SKIP: s = gpr[r.rr][r.bsel];
          OP_IO_BIT_CLEAR_SKIP: s = !r.io_val[r.bsel];
          default: s = r.io_val[r.bsel];
        endcase
        // pc step and cycle count both follow the length of the skipped word
        if (s)
        begin
          en = 2 + r.next_long;
          epc = (old + en) & M;
        end
      end
    endcase
  endtask : model

  initial
  begin
    logic [63:0] raw;
    logic [31:0] d;
    logic e;
    exec_req_t r;
    int n;
    void'($urandom(32'hBE7A));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({status_flags_reg, call_push, req_ready}, 10'h001);
    check(pc, 0);
    rd_chk(12'h080, 0);
    rd_chk(12'h084, 0);
    rd_chk(12'h07C, 0);
    for (int i = 0; i < 32; i++)
    begin
      gpr[i] = $urandom_range(0, 255);
      apb_rw(1'b1, 12'(4 * i), gpr[i], d, e);
    end
    epc = $urandom_range(0, M);
    apb_rw(1'b1, 12'h080, epc, d, e);
    flg = $urandom_range(0, 255);
    apb_rw(1'b1, 12'h084, flg, d, e);
    apb_rw(1'b0, 12'h100, 32'h0, d, e);
    check(d, 0);
    check(e, 1);
    apb_rw(1'b1, 12'h088, 32'hFF, d, e);
    check(e, 1);
    apb_rw(1'b1, 12'h002, 32'hFF, d, e);
    check(e, 1);
    rd_chk(12'h000, gpr[0]);
    for (int i = 0; i < 270; i++)
    begin
      raw = {$urandom, $urandom};
      r = raw[$bits(exec_req_t)-1:0];
      r.op = op_t'(i % 27);
      model(r);
      core_fetch_model_inst.issue(r, $urandom_range(0, 1), n);
      check(pc, epc);
      check(status_flags_reg, flg);
      check(n, en);
      check(pushes, epush);
      check(call_ret_addr, eret);
      if (i % 2)
      begin
        rd_chk(12'(4 * r.rd), gpr[r.rd]);
        rd_chk(12'(4 * ((r.rd + 1) % 32)), gpr[(r.rd + 1) % 32]);
        rd_chk(12'h088, en << 1);
      end
    end
    test_done();
  end
endmodule : core_alu_branch_exec_tb
`default_nettype wire
